// [rtl/airo_pkg.sv]
package airo_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_IRQ_SOURCE_ENABLE = 8'h2d;
  localparam logic [7:0] ADDR_IRQ_PIN_ROUTING   = 8'h2e;
  localparam logic [7:0] ADDR_X_AXIS_OFFSET     = 8'h2f;
  localparam logic [7:0] ADDR_Y_AXIS_OFFSET     = 8'h30;
  localparam logic [7:0] ADDR_Z_AXIS_OFFSET     = 8'h31;

  // ****************************************************************
  // field positions, shared by enable and routing registers
  // ****************************************************************
  localparam int BIT_SLEEP_WAKE   = 7;
  localparam int BIT_ORIENTATION  = 4;
  localparam int BIT_FALL_MOTION  = 2;
  localparam int BIT_SAMPLE_READY = 0;

  // only these bits are stored; everything else reads zero
  localparam logic [7:0] SOURCE_FIELD_MASK = 8'h95;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_IRQ_SOURCE_ENABLE = 8'h00;
  localparam logic [7:0] RST_IRQ_PIN_ROUTING   = 8'h00;
  localparam logic [7:0] RST_AXIS_OFFSET       = 8'h00;
  localparam logic [7:0] RST_READ_DATA         = 8'h00;
  localparam logic       RST_LEVEL_SEL         = 1'b0;
  localparam logic       RST_DRIVE_TYPE        = 1'b0;

  // ****************************************************************
  // offset scaling: micro-g per count and span of the signed byte
  // ****************************************************************
  localparam int OFFSET_UG_PER_LSB = 1960;
  localparam int OFFSET_SPAN_UG    = 250000;

  // ****************************************************************
  // source indices inside the packed four-source vectors
  // ****************************************************************
  localparam int SRC_SAMPLE_READY = 0;
  localparam int SRC_FALL_MOTION  = 1;
  localparam int SRC_ORIENTATION  = 2;
  localparam int SRC_SLEEP_WAKE   = 3;
  localparam int SRC_COUNT        = 4;

endpackage : airo_pkg

// [rtl/airo_pin_drv.sv]
`timescale 1ns/10ps

// ****************************************************************
// one interrupt pad: polarity and push-pull / open-drain
// ****************************************************************
module airo_pin_drv
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic irq_asserted,
  input  wire logic irq_level_sel,
  input  wire logic irq_drive_type,
  output logic      pin_o,
  output logic      pin_oe
);

  logic active_level;

  assign active_level = irq_level_sel;

  // output level; idle is the inverse of the active level
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_o <= ~airo_pkg::RST_LEVEL_SEL;
    end
    else
    begin
      pin_o <= irq_asserted ? active_level : ~active_level;
    end
  end

  // open-drain only drives while asserted, so shared lines wire-combine
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_oe <= 1'b1;
    end
    else if (irq_drive_type)
    begin
      pin_oe <= irq_asserted;
    end
    else
    begin
      pin_oe <= 1'b1;
    end
  end

endmodule : airo_pin_drv

// [rtl/airo_offset_bank.sv]
`timescale 1ns/10ps

// ****************************************************************
// per-axis zero-g offset correction bytes
// ****************************************************************
module airo_offset_bank
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       soft_rst,
  input  wire logic [2:0] axis_wr,
  input  wire logic [7:0] wdata,
  output logic [7:0]      x_axis_offset,
  output logic [7:0]      y_axis_offset,
  output logic [7:0]      z_axis_offset
);

  // signed two's complement bytes, 1.96 mg per count, no clamping needed
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      x_axis_offset <= airo_pkg::RST_AXIS_OFFSET;
    end
    else if (soft_rst)
    begin
      x_axis_offset <= airo_pkg::RST_AXIS_OFFSET;
    end
    else if (axis_wr[0])
    begin
      x_axis_offset <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      y_axis_offset <= airo_pkg::RST_AXIS_OFFSET;
    end
    else if (soft_rst)
    begin
      y_axis_offset <= airo_pkg::RST_AXIS_OFFSET;
    end
    else if (axis_wr[1])
    begin
      y_axis_offset <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      z_axis_offset <= airo_pkg::RST_AXIS_OFFSET;
    end
    else if (soft_rst)
    begin
      z_axis_offset <= airo_pkg::RST_AXIS_OFFSET;
    end
    else if (axis_wr[2])
    begin
      z_axis_offset <= wdata;
    end
  end

endmodule : airo_offset_bank

// [rtl/airo_top.sv]
// Notes on behaviour
// - Four enable bits gate the sources: sleep/wake bit 7, orientation bit 4, fall/motion bit 2, sample ready bit 0.
// - Every enable bit is 0 after reset so no source interrupts until software writes a 1.
// - Only an enabled source passes its event flag to the pins, which then drive the selected pin.
// - A routing register holds one pin-select bit per source at the same bit positions as the enables.
// - A routing bit of 0, the reset value, sends that source to the second pin.
// - A routing bit of 1 sends that source to the first pin instead.
// - Sources on the same pin are ORed, and the active_sources output shows which fired; no register reads it back.
// - Each axis has one signed 8-bit offset byte that realigns its zero-g output.
// - One offset count weighs 1.96 mg, giving about plus or minus 250 mg of correction.
// - The X, Y and Z offset bytes sit at consecutive addresses, are read/write and reset to zero.
// - The pins are active low when the level select is 0 (reset) and active high when it is 1.
// - The pins drive push-pull when the drive type is 0 (reset) and open-drain when it is 1.
`timescale 1ns/10ps

module airo_top
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       soft_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic       sleep_wake_evt,
  input  wire logic       orientation_evt,
  input  wire logic       fall_motion_evt,
  input  wire logic       sample_ready_evt,
  input  wire logic       irq_level_sel,
  input  wire logic       irq_drive_type,
  output logic [3:0]      active_sources,
  output logic            irq_pin_a_o,
  output logic            irq_pin_a_oe,
  output logic            irq_pin_b_o,
  output logic            irq_pin_b_oe,
  output logic [7:0]      x_axis_offset,
  output logic [7:0]      y_axis_offset,
  output logic [7:0]      z_axis_offset
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // decode shared by the write and read paths
  function automatic logic hits
  (
    input logic [7:0] addr,
    input logic [7:0] target
  );
    hits = (addr == target);
  endfunction : hits

  // pull the four source fields out of a register image into index order
  function automatic logic [3:0] fields
  (
    input logic [7:0] image
  );
    logic [3:0] f;
    f = 4'h0;
    f[airo_pkg::SRC_SAMPLE_READY] = image[airo_pkg::BIT_SAMPLE_READY];
    f[airo_pkg::SRC_FALL_MOTION]  = image[airo_pkg::BIT_FALL_MOTION];
    f[airo_pkg::SRC_ORIENTATION]  = image[airo_pkg::BIT_ORIENTATION];
    f[airo_pkg::SRC_SLEEP_WAKE]   = image[airo_pkg::BIT_SLEEP_WAKE];
    fields = f;
  endfunction : fields

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [7:0] irq_source_enable_q;
  logic [7:0] irq_source_enable_d;
  logic [7:0] irq_pin_routing_q;
  logic [7:0] irq_pin_routing_d;
  logic [7:0] reg_rdata_q;
  logic [7:0] reg_rdata_d;
  logic       wr_enable;
  logic       wr_routing;
  logic [2:0] wr_axis;

  // write decode; a strobe reaches at most one register
  always_comb
  begin
    wr_enable  = 1'b0;
    wr_routing = 1'b0;
    wr_axis    = 3'h0;
    if (reg_wr)
    begin
      if (hits(reg_addr, airo_pkg::ADDR_IRQ_SOURCE_ENABLE))
      begin
        wr_enable = 1'b1;
      end
      else if (hits(reg_addr, airo_pkg::ADDR_IRQ_PIN_ROUTING))
      begin
        wr_routing = 1'b1;
      end
      else if (hits(reg_addr, airo_pkg::ADDR_X_AXIS_OFFSET))
      begin
        wr_axis[0] = 1'b1;
      end
      else if (hits(reg_addr, airo_pkg::ADDR_Y_AXIS_OFFSET))
      begin
        wr_axis[1] = 1'b1;
      end
      else if (hits(reg_addr, airo_pkg::ADDR_Z_AXIS_OFFSET))
      begin
        wr_axis[2] = 1'b1;
      end
    end
  end

  // ****************************************************************
  // enable and routing registers
  // ****************************************************************

  // reserved bits are dropped on write, so they can never reach the gating
  // soft reset wins over a write in the same cycle
  always_comb
  begin
    irq_source_enable_d = irq_source_enable_q;
    if (soft_rst)
    begin
      irq_source_enable_d = airo_pkg::RST_IRQ_SOURCE_ENABLE;
    end
    else if (wr_enable)
    begin
      irq_source_enable_d = reg_wdata & airo_pkg::SOURCE_FIELD_MASK;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_source_enable_q <= airo_pkg::RST_IRQ_SOURCE_ENABLE;
    end
    else
    begin
      irq_source_enable_q <= irq_source_enable_d;
    end
  end

  always_comb
  begin
    irq_pin_routing_d = irq_pin_routing_q;
    if (soft_rst)
    begin
      irq_pin_routing_d = airo_pkg::RST_IRQ_PIN_ROUTING;
    end
    else if (wr_routing)
    begin
      irq_pin_routing_d = reg_wdata & airo_pkg::SOURCE_FIELD_MASK;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_pin_routing_q <= airo_pkg::RST_IRQ_PIN_ROUTING;
    end
    else
    begin
      irq_pin_routing_q <= irq_pin_routing_d;
    end
  end

  // ****************************************************************
  // offset bytes
  // ****************************************************************
  airo_offset_bank u_offsets
  (
    .mclk          (mclk),
    .rst           (rst),
    .soft_rst      (soft_rst),
    .axis_wr       (wr_axis),
    .wdata         (reg_wdata),
    .x_axis_offset (x_axis_offset),
    .y_axis_offset (y_axis_offset),
    .z_axis_offset (z_axis_offset)
  );

  // ****************************************************************
  // read decode
  // ****************************************************************

  // unmapped addresses read zero rather than holding stale data
  always_comb
  begin
    reg_rdata_d = airo_pkg::RST_READ_DATA;
    if (hits(reg_addr, airo_pkg::ADDR_IRQ_SOURCE_ENABLE))
    begin
      reg_rdata_d = irq_source_enable_q;
    end
    else if (hits(reg_addr, airo_pkg::ADDR_IRQ_PIN_ROUTING))
    begin
      reg_rdata_d = irq_pin_routing_q;
    end
    else if (hits(reg_addr, airo_pkg::ADDR_X_AXIS_OFFSET))
    begin
      reg_rdata_d = x_axis_offset;
    end
    else if (hits(reg_addr, airo_pkg::ADDR_Y_AXIS_OFFSET))
    begin
      reg_rdata_d = y_axis_offset;
    end
    else if (hits(reg_addr, airo_pkg::ADDR_Z_AXIS_OFFSET))
    begin
      reg_rdata_d = z_axis_offset;
    end
  end

  // ****************************************************************
  // read data register
  // ****************************************************************

  // decode uses stored values, so a read beside a write sees the old contents
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_q <= airo_pkg::RST_READ_DATA;
    end
    else if (reg_rd)
    begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign reg_rdata = reg_rdata_q;

  // ****************************************************************
  // event flags in source index order
  // ****************************************************************
  logic [3:0] evt_flags;
  logic [3:0] en_fields;
  logic [3:0] rt_fields;

  assign evt_flags[airo_pkg::SRC_SAMPLE_READY] = sample_ready_evt;
  assign evt_flags[airo_pkg::SRC_FALL_MOTION]  = fall_motion_evt;
  assign evt_flags[airo_pkg::SRC_ORIENTATION]  = orientation_evt;
  assign evt_flags[airo_pkg::SRC_SLEEP_WAKE]   = sleep_wake_evt;
  assign en_fields = fields(irq_source_enable_q);
  assign rt_fields = fields(irq_pin_routing_q);

  // ****************************************************************
  // gating and routing
  // ****************************************************************
  logic [3:0] gated;
  logic [3:0] to_pin_a;
  logic [3:0] to_pin_b;
  logic       pin_a_asserted;
  logic       pin_b_asserted;

  // a disabled source is invisible to both pins
  assign gated    = evt_flags & en_fields;
  assign to_pin_a = gated & rt_fields;
  assign to_pin_b = gated & ~rt_fields;
  assign active_sources = gated;

  // ****************************************************************
  // pin combine
  // ****************************************************************

  // several sources share a pin; software sorts them out afterwards
  always_comb
  begin
    pin_a_asserted = 1'b0;
    pin_b_asserted = 1'b0;
    for (int s = 0; s < airo_pkg::SRC_COUNT; s++)
    begin
      if (to_pin_a[s])
      begin
        pin_a_asserted = 1'b1;
      end
      if (to_pin_b[s])
      begin
        pin_b_asserted = 1'b1;
      end
    end
  end

  // ****************************************************************
  // pads
  // ****************************************************************

  // one registered stage per pad keeps the pins glitch-free
  airo_pin_drv u_pin_a
  (
    .mclk           (mclk),
    .rst            (rst),
    .irq_asserted   (pin_a_asserted),
    .irq_level_sel  (irq_level_sel),
    .irq_drive_type (irq_drive_type),
    .pin_o          (irq_pin_a_o),
    .pin_oe         (irq_pin_a_oe)
  );

  airo_pin_drv u_pin_b
  (
    .mclk           (mclk),
    .rst            (rst),
    .irq_asserted   (pin_b_asserted),
    .irq_level_sel  (irq_level_sel),
    .irq_drive_type (irq_drive_type),
    .pin_o          (irq_pin_b_o),
    .pin_oe         (irq_pin_b_oe)
  );

endmodule : airo_top

// [tb/airo_top_sva.sv]
`timescale 1ns/10ps
// ****************
// port checks
// ****************
module airo_top_chk
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       soft_rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       sample_ready_evt,
  input wire logic       irq_level_sel,
  input wire logic       irq_drive_type,
  input wire logic [3:0] active_sources,
  input wire logic       irq_pin_a_o,
  input wire logic       irq_pin_a_oe,
  input wire logic       irq_pin_b_o,
  input wire logic       irq_pin_b_oe,
  input wire logic [7:0] x_axis_offset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // shadow of the sample ready enable, rebuilt from bus writes and soft reset alone
  logic sample_ready_on_q;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sample_ready_on_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      sample_ready_on_q <= 1'b0;
    end
    else if (reg_wr && reg_addr == airo_pkg::ADDR_IRQ_SOURCE_ENABLE)
    begin
      sample_ready_on_q <= reg_wdata[airo_pkg::BIT_SAMPLE_READY];
    end
  end
  property p_rd_resv;
    reg_rd && reg_addr == airo_pkg::ADDR_IRQ_PIN_ROUTING |=> (reg_rdata & ~airo_pkg::SOURCE_FIELD_MASK) == 8'h00;
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved routing bits read back set");
  property p_rd_hold;
    !reg_rd && !soft_rst |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_off_wr;
    reg_wr && reg_addr == airo_pkg::ADDR_X_AXIS_OFFSET && !soft_rst |=> x_axis_offset == $past(reg_wdata);
  endproperty
  a_off_wr: assert property (p_off_wr) else $error("x offset not written");
  property p_src_gate;
    active_sources[0] == (sample_ready_evt && sample_ready_on_q);
  endproperty
  a_src_gate: assert property (p_src_gate) else $error("source active without its event");
  property p_idle_pp;
    active_sources == 4'h0 && !irq_drive_type |=> irq_pin_a_oe && irq_pin_a_o == !$past(irq_level_sel);
  endproperty
  a_idle_pp: assert property (p_idle_pp) else $error("idle push-pull pin at wrong level");
  property p_idle_od;
    (active_sources == 4'h0 && irq_drive_type)[*2] |-> !irq_pin_a_oe && !irq_pin_b_oe;
  endproperty
  a_idle_od: assert property (p_idle_od) else $error("idle open-drain pin driven");
  property p_asserted;
    active_sources != 4'h0 |=> (irq_pin_a_oe && irq_pin_a_o == $past(irq_level_sel))
      || (irq_pin_b_oe && irq_pin_b_o == $past(irq_level_sel));
  endproperty
  a_asserted: assert property (p_asserted) else $error("enabled source asserted no pin");
  property p_soft;
    soft_rst |-> ##1 (active_sources == 4'h0 && x_axis_offset == 8'h00);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left state behind");
  c_rd_x: cover property (reg_rd && reg_addr == airo_pkg::ADDR_X_AXIS_OFFSET);
  c_pin_a_hi: cover property (irq_pin_a_oe && irq_pin_a_o && irq_level_sel);
  c_soft: cover property (soft_rst);
endmodule : airo_top_chk

bind airo_top airo_top_chk u_airo_top_chk (.mclk(mclk), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sample_ready_evt(sample_ready_evt), .irq_level_sel(irq_level_sel), .irq_drive_type(irq_drive_type),
  .active_sources(active_sources), .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe(irq_pin_a_oe),
  .irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe(irq_pin_b_oe), .x_axis_offset(x_axis_offset));

// [tb/airo_host_model.sv]
`timescale 1ns/10ps
// ****************
// host side of the two interrupt lines
// ****************
module airo_host_model
(
  input  wire logic pin_a_o,
  input  wire logic pin_a_oe,
  input  wire logic pin_b_o,
  input  wire logic pin_b_oe,
  input  wire logic level_sel,
  output logic      irq_a_seen,
  output logic      irq_b_seen
);
  logic line_a;
  logic line_b;
  // released line pulled to the inactive level, as a shared line would be
  assign line_a     = pin_a_oe ? pin_a_o : ~level_sel;
  assign line_b     = pin_b_oe ? pin_b_o : ~level_sel;
  assign irq_a_seen = line_a == level_sel;
  assign irq_b_seen = line_b == level_sel;
endmodule : airo_host_model

// [tb/accel_irq_route_offset_test.sv]
`timescale 1ns/10ps
// ****************
// register and pin tests
// ****************
module accel_irq_route_offset_test;
  localparam logic [7:0] EN = airo_pkg::ADDR_IRQ_SOURCE_ENABLE;
  localparam logic [7:0] RT = airo_pkg::ADDR_IRQ_PIN_ROUTING;
  logic       mclk, rst, soft_rst, reg_wr, reg_rd, lvl, drv;
  logic       pa_o, pa_oe, pb_o, pb_oe, seen_a, seen_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, xo, yo, zo, m;
  logic [3:0] ev, act;
  int         miscompares, comparisons, pos[4];

  airo_top u_airo_top (.mclk(mclk), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sleep_wake_evt(ev[3]),
    .orientation_evt(ev[2]), .fall_motion_evt(ev[1]), .sample_ready_evt(ev[0]), .irq_level_sel(lvl),
    .irq_drive_type(drv), .active_sources(act), .irq_pin_a_o(pa_o), .irq_pin_a_oe(pa_oe),
    .irq_pin_b_o(pb_o), .irq_pin_b_oe(pb_oe), .x_axis_offset(xo), .y_axis_offset(yo), .z_axis_offset(zo));
  airo_host_model u_airo_host_model (.pin_a_o(pa_o), .pin_a_oe(pa_oe), .pin_b_o(pb_o), .pin_b_oe(pb_oe),
    .level_sel(lvl), .irq_a_seen(seen_a), .irq_b_seen(seen_b));

  always #10 mclk = ~mclk;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    chk("rdata", reg_rdata, exp);
  endtask : rd

  // one edge to take the inputs, one for the registered pads
  task automatic drive(input logic [3:0] e, input logic l, input logic d);
    @(posedge mclk);
    ev  <= e;
    lvl <= l;
    drv <= d;
    @(posedge mclk);
    @(negedge mclk);
  endtask : drive

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end

  initial
  begin
    {mclk, rst, soft_rst, reg_wr, reg_rd, lvl, drv} = 7'b0100000;
    {reg_addr, reg_wdata, ev} = 20'h00000;
    pos = '{0, 2, 4, 7};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(EN + i), 8'h00);
    chk("pads", {4'h0, pa_oe, pa_o, pb_oe, pb_o}, 8'h0f);
    $display("reset test done");
    wr(EN, 8'hff);
    rd(EN, 8'h95);
    wr(RT, 8'h6a);
    rd(RT, 8'h00);
    $display("reserved bit test done");
    for (int k = 0; k < 4; k++)
    begin
      m = 8'h01 << pos[k];
      wr(EN, m);
      wr(RT, 8'h00);
      drive(4'hf, 1'b0, 1'b0);
      chk("active", {4'h0, act}, 8'h01 << k);
      chk("host", {6'h0, seen_a, seen_b}, 8'h01);
      wr(RT, m);
      drive(4'hf, 1'b0, 1'b0);
      chk("host", {6'h0, seen_a, seen_b}, 8'h02);
      wr(EN, 8'h00);
      drive(4'hf, 1'b0, 1'b0);
      chk("host", {6'h0, seen_a, seen_b}, 8'h00);
    end
    $display("routing test done");
    wr(EN, 8'h15);
    wr(RT, 8'h10);
    for (int c = 0; c < 4; c++)
    begin
      drive(4'h7, c[1], c[0]);
      chk("active", {4'h0, act}, 8'h07);
      chk("pads", {4'h0, pa_oe, pa_o, pb_oe, pb_o}, {4'h0, 1'b1, c[1], 1'b1, c[1]});
      chk("host", {6'h0, seen_a, seen_b}, 8'h03);
      drive(4'h0, c[1], c[0]);
      chk("pads_oe", {6'h0, pa_oe, pb_oe}, {6'h0, ~c[0], ~c[0]});
      chk("host", {6'h0, seen_a, seen_b}, 8'h00);
    end
    $display("pad test done");
    wr(airo_pkg::ADDR_X_AXIS_OFFSET, 8'h80);
    wr(airo_pkg::ADDR_Y_AXIS_OFFSET, 8'h7f);
    wr(airo_pkg::ADDR_Z_AXIS_OFFSET, 8'hff);
    wr(8'h32, 8'h55);
    rd(airo_pkg::ADDR_X_AXIS_OFFSET, 8'h80);
    rd(airo_pkg::ADDR_Y_AXIS_OFFSET, 8'h7f);
    rd(airo_pkg::ADDR_Z_AXIS_OFFSET, 8'hff);
    rd(8'h32, 8'h00);
    chk("offsets", xo ^ yo ^ zo, 8'h00);
    $display("offset test done");
    wr(EN, 8'h95);
    @(posedge mclk);
    soft_rst <= 1'b1;
    @(posedge mclk);
    soft_rst <= 1'b0;
    rd(EN, 8'h00);
    chk("x_off", xo, 8'h00);
    $display("soft reset test done");
    conclude();
  end
endmodule : accel_irq_route_offset_test
